/* File: rtl/home_tracker_map.svh */
// Register indices, field positions, codes and reset values of the tracker
`ifndef HOME_TRACKER_MAP_SVH
`define HOME_TRACKER_MAP_SVH

// Register indices; the byte address is four times the index
`define IDX_GENERAL_CONFIGURATION   6'h00
`define IDX_REFERENCE_CONFIGURATION 6'h01
`define IDX_EVENT_FLAGS             6'h0e
`define IDX_HOME_MARGIN             6'h1e
`define IDX_HOME_POSITION           6'h20
`define IDX_STATUS                  6'h21
`define IDX_EVENT_MASK              6'h22

// Field positions
`define GEN_INVERT_TARGET_BIT 16
`define REF_ARM_BIT           0
`define REF_CODE_LSB          4
`define REF_CODE_MSB          7
`define REF_LEFT_HOME_BIT     8
`define REF_RIGHT_HOME_BIT    9
`define EV_LATCH_DONE         0
`define EV_LEFT_STOP          1
`define EV_RIGHT_STOP         2
`define EV_HOME_ERROR         3
`define ST_HOME_ERROR         0
`define ST_TARGET_REACHED     1
`define ST_ARMED              2

// Homing condition codes
`define CODE_INDEX     4'h0
`define CODE_EDGE_NEG  4'h3
`define CODE_EDGE_POS  4'hc
`define CODE_HI_CENTRE 4'h6
`define CODE_HI_LEFT   4'h2
`define CODE_HI_RIGHT  4'h4
`define CODE_LO_CENTRE 4'h9
`define CODE_LO_RIGHT  4'hb
`define CODE_LO_LEFT   4'hd

// Reset values
`define RST_WORD   32'h0000_0000
`define RST_EVENTS 4'h0

`endif

/* File: rtl/home_tracker_pkg.sv */
// Types shared by the home reference tracker
package home_tracker_pkg;

   // One APB request as the master presents it
   typedef struct packed {
      logic [7:0]  paddr;
      logic        pwrite;
      logic [31:0] pwdata;
      logic [3:0]  pstrb;
   } apb_req_t;

   // Homing sequence, Gray coded along idle, armed, wait for clear
   typedef enum logic [1:0] {
      HOME_IDLE       = 2'b00,
      HOME_ARMED      = 2'b01,
      HOME_WAIT_CLEAR = 2'b11
   } home_state_t;

   // Whether the switch is inside its home zone
   typedef enum logic {
      ZONE_OUT = 1'b0,
      ZONE_IN  = 1'b1
   } zone_state_t;

endpackage

/* File: rtl/home_reference_tracker.sv */
// Home reference tracker: homing latch, home error, limits, target pin
//
// Behaviour
// RULE1 - armed: copy position to home on condition
// RULE2 - arm bit self-clears once latch-done cleared
// RULE3 - latch sets latch-done event bit
// RULE4 - code 0000 uses encoder index, others switch
// RULE5 - codes 0011/1100: low means negative/positive side
// RULE6 - high zone codes: centre, left, right edge
// RULE7 - low zone codes: centre, right, left edge
// RULE8 - home error flag checks switch against position
// RULE9 - no home error inside home plus/minus margin
// RULE10 - index code keeps home error at zero
// RULE11 - software widens margin for zone codes
// RULE12 - left stop only after home range crossed
// RULE13 - right stop only after home range crossed
// RULE14 - target pin active when position equals goal
// RULE15 - bit 16 inverts target pin polarity
// RULE16 - software may overwrite home position anytime
// RULE17 - reading events clears pending event bits
// RULE18 - inputs synchronised, edges from synchronised samples
//
// Design decision made here: register access over APB.
`include "home_tracker_map.svh"
`timescale 1ns/1ns
`default_nettype none

module home_reference_tracker #(
   parameter int EV_W = 4
) (
   input  wire logic                       pclk,
   input  wire logic                       presetn,
   input  wire logic                       psel,
   input  wire logic                       penable,
   input  wire home_tracker_pkg::apb_req_t apb_req,
   output logic                            pready,
   output logic [31:0]                     prdata,
   output logic                            pslverr,
   input  wire logic signed [31:0]         current_position,
   input  wire logic signed [31:0]         goal_position,
   input  wire logic                       home_switch,
   input  wire logic                       encoder_index,
   input  wire logic                       left_limit_input,
   input  wire logic                       right_limit_input,
   output logic                            target_reached_pin,
   output logic                            home_error,
   output logic                            interrupt_out
);
   import home_tracker_pkg::*;

   localparam int NSYNC = 4;
   localparam int SW_H  = 0;
   localparam int SW_L  = 1;
   localparam int SW_R  = 2;
   localparam int SW_N  = 3;

   logic [31:0]        general_configuration;
   logic [31:0]        reference_configuration;
   logic [31:0]        home_margin;
   logic signed [31:0] home_position;
   logic [EV_W-1:0]    event_flags;
   logic [EV_W-1:0]    event_mask;
   logic [EV_W-1:0]    ev_set;
   logic [EV_W-1:0]    rd_clear;
   logic [NSYNC-1:0]   in_raw;
   logic [NSYNC-1:0]   in_meta;
   logic [NSYNC-1:0]   in_sync;
   logic [NSYNC-1:0]   in_prev;
   logic [1:0]         stop_pending;
   logic [1:0]         stop_set;
   home_state_t        home_state;
   home_state_t        next_home_state;
   zone_state_t        zone_state;
   logic signed [31:0] entry_pos;
   logic signed [31:0] prev_pos;
   logic               access;
   logic               mapped;
   logic               wr_en;
   logic [5:0]         reg_idx;
   logic [31:0]        rd_mux;
   logic               rd_events;
   logic [3:0]         code;
   logic               arm;
   logic               left_home;
   logic               right_home;
   logic               arm_autoclear;
   logic               sw_now;
   logic               sw_was;
   logic               sw_edge;
   logic               zone_now;
   logic               zone_was;
   logic               zone_enter;
   logic               zone_exit;
   logic               moving_pos;
   logic               moving_neg;
   logic               trigger;
   logic               latch_fire;
   logic               centre_mode;
   logic signed [32:0] mid_sum;
   logic signed [31:0] latch_value;
   logic signed [33:0] cur_x;
   logic signed [33:0] home_x;
   logic signed [33:0] marg_x;
   logic               in_margin;
   logic               below;
   logic               above;
   logic               next_error;
   logic               target_flag;

   // Byte-lane merge for APB writes
   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  strb);
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // APB slave

   // Zero wait states; unmapped or misaligned addresses give pslverr
   assign pready  = 1'b1;
   assign access  = psel & penable;
   assign reg_idx = apb_req.paddr[7:2];
   assign pslverr = access & ~mapped;
   assign wr_en   = access & apb_req.pwrite & mapped;

   // Address decode and read mux
   always_comb begin
      mapped = (apb_req.paddr[1:0] == 2'b00);
      rd_mux = `RST_WORD;
      if (reg_idx == `IDX_GENERAL_CONFIGURATION) begin
         rd_mux = general_configuration;
      end else if (reg_idx == `IDX_REFERENCE_CONFIGURATION) begin
         rd_mux = reference_configuration;
      end else if (reg_idx == `IDX_EVENT_FLAGS) begin
         rd_mux = 32'(event_flags);
      end else if (reg_idx == `IDX_HOME_MARGIN) begin
         rd_mux = home_margin;
      end else if (reg_idx == `IDX_HOME_POSITION) begin
         rd_mux = home_position;
      end else if (reg_idx == `IDX_STATUS) begin
         rd_mux[`ST_HOME_ERROR]     = home_error;
         rd_mux[`ST_TARGET_REACHED] = target_flag;
         rd_mux[`ST_ARMED]          = (home_state != HOME_IDLE);
      end else if (reg_idx == `IDX_EVENT_MASK) begin
         rd_mux = 32'(event_mask);
      end else begin
         mapped = 1'b0;
      end
   end

   // Read data captured in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= `RST_WORD;
      end else if (psel & ~penable & ~apb_req.pwrite) begin
         prdata <= rd_mux;
      end
   end

   // Only the bits that were read out are cleared
   assign rd_events = access & ~apb_req.pwrite & mapped &
                      (reg_idx == `IDX_EVENT_FLAGS);
   assign rd_clear  = rd_events ? prdata[EV_W-1:0] : '0; // RULE17

   ////////////////////////////////////////////////////////////////////////
   // Software registers

   // General configuration
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         general_configuration <= `RST_WORD;
      end else if (wr_en && reg_idx == `IDX_GENERAL_CONFIGURATION) begin
         general_configuration <= merge(general_configuration,
                                        apb_req.pwdata, apb_req.pstrb);
      end
   end

   // Reference configuration; arm bit self-clears after the handshake
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reference_configuration <= `RST_WORD;
      end else if (wr_en && reg_idx == `IDX_REFERENCE_CONFIGURATION) begin
         reference_configuration <= merge(reference_configuration,
                                          apb_req.pwdata, apb_req.pstrb);
      end else if (arm_autoclear) begin
         reference_configuration[`REF_ARM_BIT] <= 1'b0; // RULE2
      end
   end

   // Home margin and interrupt mask
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         home_margin <= `RST_WORD;
         event_mask  <= `RST_EVENTS;
      end else if (wr_en && reg_idx == `IDX_HOME_MARGIN) begin
         home_margin <= merge(home_margin, apb_req.pwdata, apb_req.pstrb);
      end else if (wr_en && reg_idx == `IDX_EVENT_MASK) begin
         event_mask <= EV_W'(merge(32'(event_mask), apb_req.pwdata,
                                   apb_req.pstrb));
      end
   end

   // Home position: software write beats a latch in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         home_position <= `RST_WORD;
      end else if (wr_en && reg_idx == `IDX_HOME_POSITION) begin
         home_position <= merge(home_position, apb_req.pwdata,
                                apb_req.pstrb); // RULE16
      end else if (latch_fire) begin
         home_position <= latch_value; // RULE1
      end
   end

   // Field views
   assign code       = reference_configuration[`REF_CODE_MSB:`REF_CODE_LSB];
   assign arm        = reference_configuration[`REF_ARM_BIT];
   assign left_home  = reference_configuration[`REF_LEFT_HOME_BIT];
   assign right_home = reference_configuration[`REF_RIGHT_HOME_BIT];

   ////////////////////////////////////////////////////////////////////////
   // Input synchronisers

   assign in_raw = {encoder_index, right_limit_input, left_limit_input,
                    home_switch};

   // Two flops per input, a third for edge detection
   for (genvar i = 0; i < NSYNC; i++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            in_meta[i] <= 1'b0;
            in_sync[i] <= 1'b0;
            in_prev[i] <= 1'b0;
         end else begin
            in_meta[i] <= in_raw[i]; // RULE18
            in_sync[i] <= in_meta[i];
            in_prev[i] <= in_sync[i];
         end
      end
   end

   // Limit inputs may stand in for the home switch
   always_comb begin
      if (left_home) begin
         sw_now = in_sync[SW_L];
         sw_was = in_prev[SW_L];
      end else if (right_home) begin
         sw_now = in_sync[SW_R];
         sw_was = in_prev[SW_R];
      end else begin
         sw_now = in_sync[SW_H];
         sw_was = in_prev[SW_H];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Position geometry

   // Motion direction from consecutive positions
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_pos <= `RST_WORD;
      end else begin
         prev_pos <= current_position;
      end
   end

   assign moving_pos = current_position > prev_pos;
   assign moving_neg = current_position < prev_pos;
   assign below      = current_position < home_position;
   assign above      = current_position > home_position;

   // Home range with inclusive bounds
   assign cur_x     = 34'(current_position);
   assign home_x    = 34'(home_position);
   assign marg_x    = $signed({2'b00, home_margin});
   assign in_margin = (cur_x >= home_x - marg_x) &&
                      (cur_x <= home_x + marg_x); // RULE9

   ////////////////////////////////////////////////////////////////////////
   // Homing conditions

   // Zone level: high codes use the switch, low codes its inverse
   always_comb begin
      centre_mode = (code == `CODE_HI_CENTRE) || (code == `CODE_LO_CENTRE);
      if (code == `CODE_HI_CENTRE || code == `CODE_HI_LEFT ||
          code == `CODE_HI_RIGHT) begin
         zone_now = sw_now; // RULE6
         zone_was = sw_was;
      end else begin
         zone_now = ~sw_now; // RULE7
         zone_was = ~sw_was;
      end
   end

   assign sw_edge    = sw_now ^ sw_was;
   assign zone_enter = zone_now & ~zone_was;
   assign zone_exit  = ~zone_now & zone_was;

   // Trigger per code; left edge is the low-position side of the zone
   always_comb begin
      case (code)
         `CODE_INDEX: begin
            trigger = in_sync[SW_N] & ~in_prev[SW_N]; // RULE4
         end
         `CODE_EDGE_NEG, `CODE_EDGE_POS: begin
            trigger = sw_edge; // RULE5
         end
         `CODE_HI_LEFT, `CODE_LO_LEFT: begin
            trigger = (zone_enter & moving_pos) |
                      (zone_exit & moving_neg); // RULE6 RULE7
         end
         `CODE_HI_RIGHT, `CODE_LO_RIGHT: begin
            trigger = (zone_enter & moving_neg) |
                      (zone_exit & moving_pos); // RULE6 RULE7
         end
         `CODE_HI_CENTRE, `CODE_LO_CENTRE: begin
            trigger = zone_exit & (zone_state == ZONE_IN);
         end
         default: begin
            trigger = 1'b0;
         end
      endcase
   end

   // Entry point of the zone, for centre latching
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         zone_state <= ZONE_OUT;
         entry_pos  <= `RST_WORD;
      end else begin
         case (zone_state)
            ZONE_OUT: begin
               if (zone_enter) begin
                  zone_state <= ZONE_IN;
                  entry_pos  <= current_position;
               end
            end
            ZONE_IN: begin
               if (!zone_now) begin // Also drops when a code change inverts the zone level
                  zone_state <= ZONE_OUT;
               end
            end
            default: begin
               zone_state <= ZONE_OUT;
            end
         endcase
      end
   end

   // Centre is the mean of entry and exit positions
   assign mid_sum     = 33'(entry_pos) + 33'(current_position);
   assign latch_value = centre_mode ? mid_sum[32:1] : current_position;
   assign latch_fire  = (home_state == HOME_ARMED) & arm & trigger; // RULE1

   ////////////////////////////////////////////////////////////////////////
   // Homing sequence

   // Arm clears only after latch-done has been read away
   assign arm_autoclear = (home_state == HOME_WAIT_CLEAR) &
                          ~event_flags[`EV_LATCH_DONE]; // RULE2

   always_comb begin
      next_home_state = home_state;
      case (home_state)
         HOME_IDLE: begin
            if (arm) begin
               next_home_state = HOME_ARMED;
            end
         end
         HOME_ARMED: begin
            if (!arm) begin
               next_home_state = HOME_IDLE;
            end else if (latch_fire) begin
               next_home_state = HOME_WAIT_CLEAR;
            end
         end
         HOME_WAIT_CLEAR: begin
            if (arm_autoclear) begin
               next_home_state = HOME_IDLE;
            end
         end
         default: begin
            next_home_state = HOME_IDLE;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         home_state <= HOME_IDLE;
      end else begin
         home_state <= next_home_state;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Home error

   // Switch level checked against side of home, outside the margin
   always_comb begin
      case (code)
         `CODE_EDGE_NEG: begin
            next_error = (below & sw_now) | (above & ~sw_now); // RULE8
         end
         `CODE_EDGE_POS: begin
            next_error = (below & ~sw_now) | (above & sw_now); // RULE8
         end
         `CODE_HI_CENTRE, `CODE_HI_LEFT, `CODE_HI_RIGHT,
         `CODE_LO_CENTRE, `CODE_LO_LEFT, `CODE_LO_RIGHT: begin
            next_error = zone_now; // RULE8
         end
         default: begin
            next_error = 1'b0; // RULE10
         end
      endcase
      if (in_margin) begin
         next_error = 1'b0; // RULE9
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         home_error <= 1'b0;
      end else begin
         home_error <= next_error;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Limit stop events

   // As home switch, a limit stops only once the home range is reached
   for (genvar s = 0; s < 2; s++) begin : g_stop
      localparam int IDX = (s == 0) ? SW_L : SW_R;
      logic as_home;
      logic rise;
      assign as_home = (s == 0) ? left_home : right_home;
      assign rise    = in_sync[IDX] & ~in_prev[IDX];
      assign stop_set[s] = as_home ?
         (stop_pending[s] & in_sync[IDX] & in_margin) :
         rise; // RULE12 RULE13
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            stop_pending[s] <= 1'b0;
         end else if (rise) begin
            stop_pending[s] <= 1'b1;
         end else if (stop_set[s] || !in_sync[IDX]) begin
            stop_pending[s] <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Events and interrupt

   always_comb begin
      ev_set                 = '0;
      ev_set[`EV_LATCH_DONE] = latch_fire; // RULE3
      ev_set[`EV_LEFT_STOP]  = stop_set[0];
      ev_set[`EV_RIGHT_STOP] = stop_set[1];
      ev_set[`EV_HOME_ERROR] = next_error & ~home_error;
   end

   // Sticky flags; a new event wins over a read-clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         event_flags <= `RST_EVENTS;
      end else begin
         event_flags <= (event_flags & ~rd_clear) | ev_set; // RULE17
      end
   end

   assign interrupt_out = |(event_flags & event_mask);

   ////////////////////////////////////////////////////////////////////////
   // Target reached pin

   assign target_flag = (current_position == goal_position); // RULE14

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         target_reached_pin <= 1'b0;
      end else begin
         target_reached_pin <= target_flag ^
            general_configuration[`GEN_INVERT_TARGET_BIT]; // RULE15
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking chk_cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence seq_latch;
      latch_fire && !(wr_en && reg_idx == `IDX_HOME_POSITION);
   endsequence

   sequence seq_home_write;
      wr_en && reg_idx == `IDX_HOME_POSITION && apb_req.pstrb == 4'hf;
   endsequence

   chk_latch_copy: assert property ( // RULE1
      seq_latch |=> home_position == $past(latch_value))
      else $error("home position not latched");

   chk_arm_release: assert property ( // RULE2
      home_state == HOME_WAIT_CLEAR && !event_flags[`EV_LATCH_DONE] &&
      !(wr_en && reg_idx == `IDX_REFERENCE_CONFIGURATION)
      |=> !arm && home_state == HOME_IDLE)
      else $error("arm bit not released");

   chk_latch_event: assert property ( // RULE3
      latch_fire |=> event_flags[`EV_LATCH_DONE] &&
                     home_state == HOME_WAIT_CLEAR)
      else $error("latch-done event missing");

   chk_index_source: assert property ( // RULE4
      home_state == HOME_ARMED && arm && code == `CODE_INDEX &&
      $rose(in_sync[SW_N]) |-> latch_fire)
      else $error("index pulse did not latch");

   chk_index_quiet: assert property ( // RULE10
      code == `CODE_INDEX [*2] |-> !home_error)
      else $error("home error with index code");

   chk_margin_quiet: assert property ( // RULE9
      in_margin |=> !home_error)
      else $error("home error inside margin");

   chk_edge_error: assert property ( // RULE8
      code == `CODE_EDGE_NEG && !in_margin && below && sw_now
      |=> home_error)
      else $error("home error not raised");

   chk_left_gate: assert property ( // RULE12
      left_home && ev_set[`EV_LEFT_STOP] |-> in_margin && in_sync[SW_L])
      else $error("left stop outside home range");

   chk_target_pin: assert property ( // RULE15
      ##1 target_reached_pin == ($past(target_flag) ^
         $past(general_configuration[`GEN_INVERT_TARGET_BIT])))
      else $error("target pin polarity wrong");

   chk_home_write: assert property ( // RULE16
      seq_home_write |=> home_position == $past(apb_req.pwdata))
      else $error("home position write lost");

   chk_read_clear: assert property ( // RULE17
      rd_events && ev_set == '0 |=> (event_flags & $past(prdata[EV_W-1:0]))
                                    == '0 ##1 !rd_events [*1])
      else $error("event read did not clear");

endmodule

`default_nettype wire

/* File: tb/home_ref_model.sv */
// Home switch and encoder index model
`timescale 1ns/1ns
`default_nettype none
module home_ref_model (
   input  wire logic pclk,
   output var logic  home_switch,
   output var logic  encoder_index
);
   initial begin
      home_switch = 1'b0;
      encoder_index = 1'b0;
   end
   // Switch level, moved just after an edge
   task automatic set_sw(input logic v);
      @(posedge pclk);
      home_switch <= v;
   endtask
   // Index pulse, four clocks wide
   task automatic pulse_idx();
      @(posedge pclk);
      encoder_index <= 1'b1;
      repeat (4) @(posedge pclk);
      encoder_index <= 1'b0;
   endtask
endmodule
`default_nettype wire

/* File: tb/home_reference_tracker_tb.sv */
// Bench for the home reference tracker
`include "home_tracker_map.svh"
`timescale 1ns/1ns
`default_nettype none
module home_reference_tracker_tb;
   import home_tracker_pkg::*;
   logic               pclk = 1'b0;
   logic               presetn = 1'b0;
   logic               psel = 1'b0;
   logic               penable = 1'b0;
   apb_req_t           apb_req = '0;
   logic signed [31:0] cur = 32'sd0;
   logic signed [31:0] goal = 32'sd7;
   logic               lim_l = 1'b0;
   logic               lim_r = 1'b0;
   wire logic          pready, pslverr, tr_pin, herr, irq, sw, idx;
   wire logic [31:0]   prdata;
   logic [31:0]        rd;
   logic               err;
   int                 n_mismatch = 0;
   int                 n_checks = 0;
   // Clock
   always #5 pclk = ~pclk;
   home_reference_tracker uut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .apb_req(apb_req),
      .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .current_position(cur), .goal_position(goal),
      .home_switch(sw), .encoder_index(idx),
      .left_limit_input(lim_l), .right_limit_input(lim_r),
      .target_reached_pin(tr_pin), .home_error(herr),
      .interrupt_out(irq));
   home_ref_model partner (.pclk(pclk), .home_switch(sw),
      .encoder_index(idx));
   task automatic chk(input string what, input logic [31:0] seen, exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // One APB transfer, setup then access until pready
   task automatic apb(input logic wr, input logic [5:0] ix,
                      input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      apb_req <= '{paddr: {ix, 2'b00}, pwrite: wr, pwdata: wd,
                   pstrb: 4'hf};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic t_target();
      chk("tr_off", tr_pin, 0);
      goal <= 32'sd0;
      repeat (3) @(posedge pclk);
      chk("tr_on", tr_pin, 1);
      apb(1, `IDX_GENERAL_CONFIGURATION, 32'h0001_0000);
      repeat (3) @(posedge pclk);
      chk("tr_inv_on", tr_pin, 0);
      goal <= 32'sd5;
      repeat (3) @(posedge pclk);
      chk("tr_inv_off", tr_pin, 1);
      $display("target test done");
   endtask
   task automatic t_index();
      apb(1, `IDX_EVENT_MASK, 32'h1);
      apb(1, `IDX_REFERENCE_CONFIGURATION, 32'h1);
      cur <= 32'sd1234;
      partner.set_sw(1'b1);
      repeat (8) @(posedge pclk);
      chk("no_sw_irq", irq, 0);
      partner.pulse_idx();
      repeat (8) @(posedge pclk);
      chk("irq_set", irq, 1);
      apb(0, `IDX_HOME_POSITION, 0);
      chk("home_idx", rd, 32'd1234);
      apb(0, `IDX_EVENT_FLAGS, 0);
      chk("ev_done", rd[0], 1);
      apb(0, `IDX_EVENT_FLAGS, 0);
      chk("ev_clr", rd[0], 0);
      chk("irq_clr", irq, 0);
      apb(0, `IDX_REFERENCE_CONFIGURATION, 0);
      chk("arm_clr", rd[0], 0);
      partner.set_sw(1'b0);
      $display("index test done");
   endtask
   task automatic t_edge();
      apb(1, `IDX_EVENT_MASK, 32'h0);
      apb(1, `IDX_HOME_MARGIN, 32'd10);
      apb(1, `IDX_REFERENCE_CONFIGURATION, 32'h31);
      cur <= 32'sd500;
      partner.set_sw(1'b1);
      repeat (8) @(posedge pclk);
      chk("irq_mask", irq, 0);
      apb(0, `IDX_HOME_POSITION, 0);
      chk("home_edge", rd, 32'd500);
      apb(0, `IDX_EVENT_FLAGS, 0);
      cur <= 32'sd490;
      repeat (5) @(posedge pclk);
      chk("err_bound", herr, 0);
      cur <= 32'sd489;
      repeat (5) @(posedge pclk);
      chk("err_side", herr, 1);
      apb(1, `IDX_REFERENCE_CONFIGURATION, 32'h0);
      repeat (5) @(posedge pclk);
      chk("err_index", herr, 0);
      $display("edge test done");
   endtask
   task automatic t_regs();
      apb(1, `IDX_HOME_POSITION, 32'h1234_5678);
      apb(0, `IDX_HOME_POSITION, 0);
      chk("home_wr", rd, 32'h1234_5678);
      apb(0, 6'h3f, 0);
      chk("unmapped_err", err, 1);
      chk("unmapped_rd", rd, 0);
      $display("register test done");
   endtask
   // Centre latch on a high (lo=0) or low (lo=1) level zone
   task automatic t_zone(input logic lo);
      apb(0, `IDX_EVENT_FLAGS, 0);
      partner.set_sw(lo);
      apb(1, `IDX_REFERENCE_CONFIGURATION, lo ? 32'h91 : 32'h61);
      cur <= 32'sd200;
      partner.set_sw(~lo);
      repeat (5) @(posedge pclk);
      cur <= 32'sd300;
      partner.set_sw(lo);
      repeat (5) @(posedge pclk);
      apb(0, `IDX_HOME_POSITION, 0);
      chk("home_centre", rd, 32'd250);
      $display("zone test done");
   endtask
   // Limit as home switch: stop only inside the home range
   task automatic t_limit(input int s);
      cur <= 32'sd0;
      apb(1, `IDX_HOME_POSITION, 32'd100);
      apb(1, `IDX_REFERENCE_CONFIGURATION, 32'h100 << s);
      if (s == 0) lim_l <= 1'b1;
      else lim_r <= 1'b1;
      repeat (6) @(posedge pclk);
      apb(0, `IDX_EVENT_FLAGS, 0);
      chk("stop_early", rd[1+s], 0);
      cur <= 32'sd95 + 10 * s;
      repeat (6) @(posedge pclk);
      apb(0, `IDX_EVENT_FLAGS, 0);
      chk("stop_home", rd[1+s], 1);
      lim_l <= 1'b0;
      lim_r <= 1'b0;
      $display("limit test done");
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      t_target();
      t_index();
      t_edge();
      t_zone(1'b0);
      t_zone(1'b1);
      t_limit(0);
      t_limit(1);
      t_regs();
      report_and_stop();
   end
   // Watchdog
   initial begin
      repeat (5000) @(posedge pclk);
      n_mismatch++;
      report_and_stop();
   end
endmodule
`default_nettype wire
